/* px_crossbar.sv */
// Priority pin crossbar with event capture and analog input routing
`timescale 1ns/1ps
`include "px_defines.svh"
module px_crossbar (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [7:0] function_select_0,
	input wire logic [7:0] function_select_1,
	input wire logic [7:0] function_select_2,
	input wire logic [7:0] port0_skip_mask,
	input wire logic [7:0] port1_skip_mask,
	input wire logic [7:0] port2_skip_mask,
	input wire px_pkg::px_pins_t output_mode_select,
	input wire px_pkg::px_pins_t port_latch,
	input wire px_pkg::px_pins_t pin_analog,
	input wire logic spi_a_four_wire,
	input wire logic spi_b_four_wire,
	input wire logic vref_en,
	input wire logic analog_ground_ref_en,
	input wire logic xtal_en,
	input wire logic iref_en,
	input wire px_pkg::px_fn_t fn_out,
	input wire px_pkg::px_fn_t fn_oe,
	output logic [25:0] fn_in,
	input wire px_pkg::px_pins_t pad_i,
	output logic [22:0] pad_o,
	output logic [22:0] pad_oe,
	input wire logic [7:0] ext_irq_pin_config,
	output logic ext_irq0_r,
	output logic ext_irq1_r,
	output logic ext_irq0_edge_r,
	output logic ext_irq1_edge_r,
	input wire logic [7:0] port0_match_mask,
	input wire logic [7:0] port0_match_value,
	input wire logic [7:0] port1_match_mask,
	input wire logic [7:0] port1_match_value,
	input wire logic small_package,
	output logic port_match_r,
	input wire px_pkg::px_sel_t adc_input_select,
	input wire px_pkg::px_sel_t cmp0_input_select,
	input wire px_pkg::px_sel_t cmp1_input_select,
	output logic [22:0] adc_route,
	output logic [22:0] cmp0_route,
	output logic [22:0] cmp1_route
);
	import px_pkg::*;

	//------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------
	px_code_t owner_r [`PX_NPIN]; // Registered pin owner map
	px_code_t owner_nxt [`PX_NPIN]; // Next owner map from the search
	px_pins_t skip; // Combined skip mask, P2.7 dropped
	logic [`PX_NSLOT:1] req; // Requested crossbar slots
	px_pins_t sync1_r; // First pad synchroniser stage
	px_pins_t sync2_r; // Second pad synchroniser stage
	px_pins_t pin_rd; // Digital read value, analog reads 0
	px_pins_t fixed_ana; // Pins claimed by fixed analog functions
	px_pins_t pad_o_r, pad_o_nxt; // Registered pad value
	px_pins_t pad_oe_r, pad_oe_nxt; // Registered pad enable
	px_fn_t fn_in_r, fn_in_nxt; // Registered peripheral inputs
	logic irq0_nxt, irq1_nxt; // Next interrupt levels
	logic match_nxt; // Next port match state
	px_pins_t adc_r, cmp0_r, cmp1_r; // Registered analog routes
	logic [2:0] ch_cnt; // Number of counter channels routed
	logic xbar_en; // Crossbar enable bit

	// One-hot pin decode; codes above P2.6 select nothing
	function automatic px_pins_t pin_onehot(input px_sel_t sel);
		px_pins_t v;
		v = '0;
		if (sel < 5'(`PX_NPIN))
			v[sel] = 1'b1;
		return v;
	endfunction

	assign xbar_en = function_select_2[`PX_SEL2_XBAR_EN];
	// P2.7 has no place in the skip vector: it is never a candidate
	assign skip = {port2_skip_mask[6:0], port1_skip_mask,
		port0_skip_mask};

	//------------------------------------------------------------------
	// Slot requests in priority order
	//------------------------------------------------------------------
	// Counter channels are cumulative; the reserved code routes none
	always_comb
	begin
		ch_cnt = function_select_1[`PX_SEL1_CH_LSB +: 3];
		if (ch_cnt == 3'h7)
			ch_cnt = 3'h0;
		req = '0;
		req[3:1] = {3{function_select_0[`PX_SEL0_SPIA]}};
		req[4] = function_select_0[`PX_SEL0_SPIA]
			& spi_a_four_wire;
		req[6:5] = {2{function_select_0[`PX_SEL0_SMB]}};
		// Comparators: A before B, each synchronous before asynchronous
		req[7] = function_select_0[`PX_SEL0_CMPA];
		req[8] = function_select_0[`PX_SEL0_CMPA_ASYNC];
		req[9] = function_select_0[`PX_SEL0_CMPB];
		req[10] = function_select_0[`PX_SEL0_CMPB_ASYNC];
		req[11] = function_select_0[`PX_SEL0_SYSCK];
		for (int c = 0; c < 6; c++)
			req[12 + c] = (3'(c) < ch_cnt);
		req[18] = function_select_1[`PX_SEL1_ECI];
		req[19] = function_select_1[`PX_SEL1_T0];
		req[20] = function_select_1[`PX_SEL1_T1];
	end

	//------------------------------------------------------------------
	// Priority search
	//------------------------------------------------------------------
	// Fixed-pin peripherals first, then a lowest-free-pin walk per slot.
	// Long combinational chain, but it only has to settle in one cycle.
	always_comb
	begin
		logic found;
		found = 1'b0;
		for (int p = 0; p < `PX_NPIN; p++)
			owner_nxt[p] = `PX_FN_NONE;
		// Skipped fixed pins stay reserved even when selected
		if (function_select_0[`PX_SEL0_UART])
		begin
			if (!skip[`PX_PIN_UART_TX])
				owner_nxt[`PX_PIN_UART_TX] = `PX_FN_UART_TX;
			if (!skip[`PX_PIN_UART_RX])
				owner_nxt[`PX_PIN_UART_RX] = `PX_FN_UART_RX;
		end
		if (function_select_1[`PX_SEL1_SPIB])
		begin
			for (int k = 0; k < 4; k++)
				if ((k < 3 || spi_b_four_wire) &&
					!skip[`PX_PIN_SPIB_SCK + k])
					owner_nxt[`PX_PIN_SPIB_SCK + k] =
						`PX_FN_SPIB_SCK + 5'(k);
		end
		// Slot number doubles as the owner code of the pin it wins
		for (int s = 1; s <= `PX_NSLOT; s++)
		begin
			found = 1'b0;
			if (req[s])
				for (int p = 0; p < `PX_NPIN; p++)
					if (!found && !skip[p] &&
						owner_nxt[p] == `PX_FN_NONE)
					begin
						owner_nxt[p] = 5'(s);
						found = 1'b1;
					end
		end
	end

	// Owner map register: settings act on the next cycle
	// Registering the map keeps the long search off the pad path
	always_ff @(posedge mclk)
	begin
		for (int p = 0; p < `PX_NPIN; p++)
			if (srst)
				owner_r[p] <= `PX_OWNER_RST;
			else
				owner_r[p] <= owner_nxt[p];
	end

	//------------------------------------------------------------------
	// Pad input synchroniser
	//------------------------------------------------------------------
	// Two stages against metastability; only the second stage is read.
	// Reset loads the pulled-up idle level, so an active-low interrupt
	// line sees no false edge when reset lets go.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			// Pads idle high through their weak pull-ups
			sync1_r <= '1;
			sync2_r <= '1;
		end
		else
		begin
			// Second stage only ever samples the first
			sync1_r <= pad_i;
			sync2_r <= sync1_r;
		end
	end

	// Analog pins read back zero; the event logic masks them out separately
	assign pin_rd = sync2_r & ~pin_analog;

	// Enabled fixed analog functions keep every driver off their pins
	assign fixed_ana = {15'h0000,
		iref_en, 3'h0,
		xtal_en, xtal_en,
		analog_ground_ref_en, vref_en};

	//------------------------------------------------------------------
	// Pad drive and peripheral input routing
	//------------------------------------------------------------------
	generate
		for (genvar p = 0; p < `PX_NPIN; p++)
		begin : g_pin
			// Per-pin value, mode and enable from its owner
			always_comb
			begin
				logic val, drv, push;
				px_code_t code;
				code = owner_r[p];
				// GPIO default: latch value in the selected output mode
				val = port_latch[p];
				drv = 1'b1;
				push = output_mode_select[p];
				if (code != `PX_FN_NONE)
				begin
					val = fn_out[code - 5'h01];
					drv = fn_oe[code - 5'h01];
				end
				if (code == `PX_FN_SMB_SDA || code == `PX_FN_SMB_SCL)
					push = 1'b0;
				// Open-drain only pulls low; a high value releases the pad
				pad_o_nxt[p] = push & val;
				pad_oe_nxt[p] = xbar_en & drv & ~pin_analog[p] &
					~fixed_ana[p] & (push | ~val);
			end
		end
		for (genvar f = 0; f < `PX_NFN; f++)
		begin : g_fn
			// Peripheral input follows the pin that owns the function
			always_comb
			begin
				// Unowned lines read 0, so an idle peripheral sees nothing
				fn_in_nxt[f] = 1'b0;
				for (int p = 0; p < `PX_NPIN; p++)
					if (owner_r[p] == 5'(f + 1))
						fn_in_nxt[f] = pin_rd[p];
			end
		end
	endgenerate

	//------------------------------------------------------------------
	// Event capture
	//------------------------------------------------------------------
	// Low three bits pick the P0 pin, bit 3 sets active high.
	// An analog pin reads 0, which an active-low line would take as
	// a request, so analog pins are masked out of every event.
	always_comb
	begin
		// Interrupt 0 level
		irq0_nxt = (pin_rd[ext_irq_pin_config[2:0]]
			^ ~ext_irq_pin_config[3])
			& ~pin_analog[ext_irq_pin_config[2:0]];
		// Interrupt 1 level
		irq1_nxt = (pin_rd[ext_irq_pin_config[6:4]]
			^ ~ext_irq_pin_config[7])
			& ~pin_analog[ext_irq_pin_config[6:4]];
		// Any masked digital pin that differs from its match value; the small package drops P1.6 and P1.7
		match_nxt = (({port1_match_mask, port0_match_mask} &
			~pin_analog[15:0] &
			(pin_rd[15:0] ^ {port1_match_value, port0_match_value})) &
			(small_package ? `PX_MATCH_SMALL_MASK : 16'hFFFF))
			!= 16'h0000;
	end

	//------------------------------------------------------------------
	// Output registers
	//------------------------------------------------------------------
	// Every output leaves a flip-flop; reset clears them all
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pad_o_r <= '0;
			pad_oe_r <= '0;
			fn_in_r <= '0;
			ext_irq0_r <= `PX_BIT_RST;
			ext_irq1_r <= `PX_BIT_RST;
			ext_irq0_edge_r <= `PX_BIT_RST;
			ext_irq1_edge_r <= `PX_BIT_RST;
			port_match_r <= `PX_BIT_RST;
			adc_r <= '0;
			cmp0_r <= '0;
			cmp1_r <= '0;
		end
		else
		begin
			pad_o_r <= pad_o_nxt;
			pad_oe_r <= pad_oe_nxt;
			fn_in_r <= fn_in_nxt;
			ext_irq0_r <= irq0_nxt;
			ext_irq1_r <= irq1_nxt;
			// One-cycle pulse on the rising active level
			ext_irq0_edge_r <= irq0_nxt & ~ext_irq0_r;
			ext_irq1_edge_r <= irq1_nxt & ~ext_irq1_r;
			port_match_r <= match_nxt;
			// Analog routes ignore the skip masks: software reserves them
			adc_r <= pin_onehot(adc_input_select);
			cmp0_r <= pin_onehot(cmp0_input_select);
			cmp1_r <= pin_onehot(cmp1_input_select);
		end
	end

	assign pad_o = pad_o_r;
	assign pad_oe = pad_oe_r;
	assign fn_in = fn_in_r;
	assign adc_route = adc_r;
	assign cmp0_route = cmp0_r;
	assign cmp1_route = cmp1_r;
endmodule // px_crossbar

/* px_defines.svh */
// Constants for the priority pin crossbar: offsets, fields, codes, resets
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef PX_DEFINES_SVH
`define PX_DEFINES_SVH

// Pin and function counts
`define PX_NPIN 23
`define PX_NSLOT 20
`define PX_NFN 26

// function_select_0 field positions
`define PX_SEL0_UART 0
`define PX_SEL0_SPIA 1
`define PX_SEL0_SMB 2
`define PX_SEL0_SYSCK 3
`define PX_SEL0_CMPA 4
`define PX_SEL0_CMPA_ASYNC 5
`define PX_SEL0_CMPB 6
`define PX_SEL0_CMPB_ASYNC 7
// function_select_1 field positions
`define PX_SEL1_CH_LSB 0
`define PX_SEL1_ECI 3
`define PX_SEL1_T0 4
`define PX_SEL1_T1 5
`define PX_SEL1_SPIB 6
// function_select_2 field position
`define PX_SEL2_XBAR_EN 6

// Function codes carried by the pin owner map, 0 means GPIO
`define PX_FN_NONE 5'h00
`define PX_FN_SPIA_SCK 5'h01
`define PX_FN_SPIA_NSS 5'h04
`define PX_FN_SMB_SDA 5'h05
`define PX_FN_SMB_SCL 5'h06
`define PX_FN_UART_TX 5'h15
`define PX_FN_UART_RX 5'h16
`define PX_FN_SPIB_SCK 5'h17
`define PX_FN_SPIB_NSS 5'h1A

// Fixed pin indices (port*8 + bit), then the small-package match mask
`define PX_PIN_VREF 0
`define PX_PIN_ANALOG_GROUND_REF 1
`define PX_PIN_XTAL_IN 2
`define PX_PIN_XTAL_OUT 3
`define PX_PIN_UART_TX 4
`define PX_PIN_UART_RX 5
`define PX_PIN_IREF 7
`define PX_PIN_SPIB_SCK 8
`define PX_MATCH_SMALL_MASK 16'h3FFF

// Reset values
`define PX_OWNER_RST 5'h00
`define PX_BIT_RST 1'b0

`endif

/* px_pkg.sv */
// Types shared by the priority pin crossbar
package px_pkg;
	// Owner code of one pin: 0 GPIO, 1..20 crossbar slots, 21..26 fixed
	typedef logic [4:0] px_code_t;
	// One bit per assignable pin P0.0..P2.6
	typedef logic [22:0] px_pins_t;
	// One bit per function line
	typedef logic [25:0] px_fn_t;
	// Analog input select code
	typedef logic [4:0] px_sel_t;
endpackage

/* px_crossbar_props.sv */
// Checker for the crossbar pad, event and route outputs
`timescale 1ns/1ps
module px_crossbar_props (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [7:0] function_select_0,
	input wire logic [7:0] function_select_2,
	input wire logic [7:0] port0_skip_mask,
	input wire px_pkg::px_pins_t output_mode_select,
	input wire px_pkg::px_pins_t pin_analog,
	input wire px_pkg::px_fn_t fn_oe,
	input wire logic [22:0] pad_o,
	input wire logic [22:0] pad_oe,
	input wire logic [7:0] ext_irq_pin_config,
	input wire logic ext_irq0_r,
	input wire logic ext_irq0_edge_r,
	input wire logic small_package,
	input wire logic [7:0] port0_match_mask,
	input wire logic [7:0] port1_match_mask,
	input wire logic port_match_r,
	input wire px_pkg::px_sel_t adc_input_select,
	input wire logic [22:0] adc_route
);
	// ----------
	// Properties
	// ----------
	// Settings need two edges to reach the pads, so the pad and route windows are three long
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	property p_off;
		(!function_select_2[6])[*3] |-> pad_oe == 23'h0;
	endproperty
	a_off: assert property (p_off) else $error("drive while off");
	property p_uart;
		(function_select_0[0] && function_select_2[6] && !port0_skip_mask[4]
			&& fn_oe[20] && output_mode_select[4])[*3] |-> pad_oe[4];
	endproperty
	a_uart: assert property (p_uart) else $error("tx pin idle");
	property p_smb;
		(function_select_0[2:1] == 2'b10 && function_select_2[6]
			&& port0_skip_mask[1:0] == 2'b00)[*3] |-> pad_o[1:0] == 2'b00;
	endproperty
	a_smb: assert property (p_smb) else $error("bus pin pulled up");
	property p_route;
		($stable(adc_input_select) && adc_input_select < 5'h17)[*3]
			|-> adc_route == (23'h1 << adc_input_select);
	endproperty
	a_route: assert property (p_route) else $error("bad route");
	property p_none;
		(adc_input_select > 5'h16)[*3] |-> adc_route == 23'h0;
	endproperty
	a_none: assert property (p_none) else $error("stray route");
	property p_pulse;
		ext_irq0_edge_r |=> !ext_irq0_edge_r;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_analog;
		(pin_analog[ext_irq_pin_config[2:0]]
			&& $stable(ext_irq_pin_config))[*5] |-> !ext_irq0_r;
	endproperty
	a_analog: assert property (p_analog) else $error("analog irq");
	property p_small;
		(small_package && port0_match_mask == 8'h0
			&& port1_match_mask[5:0] == 6'h0)[*4] |-> !port_match_r;
	endproperty
	a_small: assert property (p_small) else $error("match on P1.6");
endmodule // px_crossbar_props
bind px_crossbar px_crossbar_props px_crossbar_props_i (.*);

/* px_pads.sv */
// Pad-side model: a pad shows its own drive or the outside level
`timescale 1ns/1ps
module px_pads (
	input wire logic [22:0] pad_o,
	input wire logic [22:0] pad_oe,
	input wire logic [22:0] ext_lvl,
	output logic [22:0] pad_i
);
	// Released pads follow the board level on ext_lvl; the model has no pull-up
	assign pad_i = (pad_o & pad_oe) | (ext_lvl & ~pad_oe);
endmodule // px_pads

/* test_px_crossbar.sv */
// Testbench for the priority pin crossbar
`timescale 1ns/1ps
module test_px_crossbar;
	import px_pkg::*;
	// ----
	// Nets
	// ----
	logic mclk, srst, spi_a_four_wire, spi_b_four_wire, small_package;
	logic vref_en, analog_ground_ref_en, xtal_en, iref_en, port_match_r;
	logic [7:0] function_select_0, function_select_1, function_select_2;
	logic [7:0] port0_skip_mask, port1_skip_mask, port2_skip_mask;
	logic [7:0] ext_irq_pin_config, port0_match_mask, port0_match_value;
	logic [7:0] port1_match_mask, port1_match_value;
	px_pins_t output_mode_select, port_latch, pin_analog, pad_i, ext_lvl;
	px_fn_t fn_out, fn_oe;
	px_sel_t adc_input_select, cmp0_input_select, cmp1_input_select;
	logic [25:0] fn_in;
	logic [22:0] pad_o, pad_oe, adc_route, cmp0_route, cmp1_route;
	logic ext_irq0_r, ext_irq1_r, ext_irq0_edge_r, ext_irq1_edge_r;
	int fails, checked, n;
	px_crossbar px_crossbar_i (.*);
	px_pads px_pads_i (.*);
	// Free-running clock
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// -----
	// Tasks
	// -----
	task automatic chk(input logic [22:0] got, input logic [22:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Selects apply on one edge and reach pads on the next; wait four
	task automatic sel(input logic [7:0] a, b, c);
		function_select_0 = a;
		function_select_1 = b;
		function_select_2 = c;
		repeat (4) @(negedge mclk);
	endtask
	task automatic wt(input int k);
		repeat (k) @(negedge mclk);
	endtask
	task automatic conclude();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Open-drain with fn_out 0: pad_oe is exactly the owned output pins
	task automatic t_alloc();
		sel(8'h01, 8'h00, 8'h00);
		chk(pad_oe, 23'h0);
		sel(8'h01, 8'h00, 8'h40);
		chk(pad_oe, 23'h10);
		// Fixed analog functions keep low-driving GPIO off their pins
		port_latch = 23'h7FFF70;
		{vref_en, analog_ground_ref_en, xtal_en, iref_en} = 4'hF;
		wt(4);
		chk(pad_oe, 23'h10);
		port_latch = '1;
		{vref_en, analog_ground_ref_en, xtal_en, iref_en} = 4'h0;
		port0_skip_mask = 8'h0C;
		spi_b_four_wire = 1'b1;
		sel(8'h03, 8'h40, 8'h40);
		chk(pad_oe, 23'hF53);
		port0_skip_mask = 8'h00;
		spi_a_four_wire = 1'b1;
		sel(8'h06, 8'h03, 8'h40);
		chk(pad_oe, 23'h1FF);
		sel(8'h06, 8'h07, 8'h40);
		chk(pad_oe, 23'h3F);
		spi_a_four_wire = 1'b0;
		sel(8'h06, 8'h03, 8'h40);
		chk(pad_oe, 23'hFF);
		port1_skip_mask = 8'hFF;
		sel(8'hFE, 8'h3E, 8'h40);
		chk(pad_oe, 23'h7F00FF);
		port1_skip_mask = 8'h00;
		output_mode_select = '1;
		fn_out = '1;
		sel(8'h0D, 8'h00, 8'h40);
		chk(pad_oe & 23'h7, 23'h4);
		chk(pad_o & 23'h14, 23'h14);
		// Receive line on P0.5 follows the board level, three edges late
		wt(2);
		chk(23'(fn_in >> 21), 23'h1);
		ext_lvl[5] = 1'b0;
		wt(4);
		chk(23'(fn_in >> 21), 23'h0);
		ext_lvl[5] = 1'b1;
		output_mode_select = '0;
		fn_out = '0;
		$display("alloc done");
	endtask
	// Interrupt level and edge, analog pins, port match
	task automatic t_events();
		sel(8'h00, 8'h00, 8'h00);
		ext_irq_pin_config = 8'h0B;
		ext_lvl[3] = 1'b0;
		wt(5);
		chk(23'(ext_irq0_r), 23'h0);
		chk(23'(ext_irq1_r), 23'h0);
		ext_lvl[3] = 1'b1;
		n = 0;
		repeat (6)
		begin
			@(negedge mclk);
			n += int'(ext_irq0_edge_r === 1'b1);
		end
		chk(23'(n), 23'h1);
		chk(23'(ext_irq0_r), 23'h1);
		// Active-low line on P0.0 rises as the pad falls
		ext_lvl[0] = 1'b0;
		n = 0;
		repeat (6)
		begin
			@(negedge mclk);
			n += int'(ext_irq1_edge_r === 1'b1);
		end
		chk(23'(n), 23'h1);
		chk(23'(ext_irq1_r), 23'h1);
		// Parked analog pins raise no event of either polarity
		port0_skip_mask = 8'h09;
		pin_analog[3] = 1'b1;
		pin_analog[0] = 1'b1;
		port0_match_mask = 8'h08;
		port0_match_value = 8'h08;
		wt(6);
		chk(23'(ext_irq0_r), 23'h0);
		chk(23'(ext_irq1_r), 23'h0);
		chk(23'(port_match_r), 23'h0);
		ext_lvl[0] = 1'b1;
		pin_analog = '0;
		port0_skip_mask = 8'h00;
		port0_match_value = 8'h00;
		wt(5);
		chk(23'(port_match_r), 23'h1);
		port0_match_mask = 8'h00;
		port1_match_mask = 8'h40;
		wt(5);
		chk(23'(port_match_r), 23'h1);
		small_package = 1'b1;
		wt(5);
		chk(23'(port_match_r), 23'h0);
		$display("events done");
	endtask
	// Analog input selects give one-hot routes
	task automatic t_route();
		adc_input_select = 5'h16;
		cmp1_input_select = 5'h09;
		wt(4);
		chk(adc_route, 23'h400000);
		chk(cmp0_route, 23'h1);
		chk(cmp1_route, 23'h200);
		adc_input_select = 5'h1F;
		wt(4);
		chk(adc_route, 23'h0);
		$display("route done");
	endtask
	// ----
	// Main
	// ----
	initial
	begin
		{function_select_0, function_select_1, function_select_2} = '0;
		{port0_skip_mask, port1_skip_mask, port2_skip_mask} = '0;
		{ext_irq_pin_config, port0_match_mask, port0_match_value} = '0;
		{port1_match_mask, port1_match_value, adc_input_select} = '0;
		{cmp0_input_select, cmp1_input_select, output_mode_select} = '0;
		{spi_a_four_wire, spi_b_four_wire, small_package, vref_en} = '0;
		{analog_ground_ref_en, xtal_en, iref_en, pin_analog, fn_out} = '0;
		port_latch = '1;
		ext_lvl = '1;
		// Receive and counting inputs never drive their pins
		fn_oe = 26'h3D1FFFF;
		srst = 1'b1;
		wt(6);
		srst = 1'b0;
		wt(1);
		t_alloc();
		t_events();
		t_route();
		conclude();
	end
	// Watchdog, far beyond the hundred or so cycles the tests take
	initial
	begin
		#400000;
		fails++;
		conclude();
	end
endmodule // test_px_crossbar
